// ===== inc/imrid_if.sv
// imrid_if: two-wire bus between host and memory slave
// resolves open-drain data and host-driven clock; released lines read high
`timescale 1ns/1ns
interface imrid_if;
  logic sclOut;
  logic sclOe;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic scl;
  logic sda;

  assign scl = sclOe ? sclOut : 1'b1;
  assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));

  modport dev  (input scl, sda, output sdaDevOut, sdaDevOe);
  modport host (input sda, output sclOut, sclOe, sdaHostOut, sdaHostOe);
endinterface

// ===== inc/imrid_pkg.sv
// imrid_pkg: constants and types shared by both ends of the serial memory link
// assumes a single 250 MHz ref_clk in every module
package imrid_pkg;
  localparam int CLK_PERIOD_NS = 4;
  // host bit rate: 400 kHz, one bit is four quarters
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC       = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

  localparam int ADDR_W    = 15;
  localparam int MEM_WORDS = 32768;

  localparam logic [3:0] DEV_TYPE    = 4'ha;
  localparam logic [7:0] RSV_ID_SET  = 8'hf8;
  localparam logic [7:0] RSV_ID_READ = 8'hf9;
  localparam logic [1:0] ID_LAST     = 2'h2;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] ACK_SEEN    = 4'h9;
  localparam logic [1:0] Q_HIGH      = 2'h2;
  localparam logic [1:0] Q_LAST      = 2'h3;

  // host symbol sequence
  localparam logic [2:0] STEP_LEAD    = 3'h0;
  localparam logic [2:0] STEP_W1      = 3'h1;
  localparam logic [2:0] STEP_W2      = 3'h2;
  localparam logic [2:0] STEP_W3      = 3'h3;
  localparam logic [2:0] STEP_RESTART = 3'h4;
  localparam logic [2:0] STEP_W5      = 3'h5;
  localparam logic [2:0] STEP_READ    = 3'h6;
  localparam logic [2:0] STEP_STOP    = 3'h7;

  typedef enum logic [2:0] {
    DST_IDLE  = 3'b000,
    DST_RX    = 3'b001,
    DST_ACK   = 3'b010,
    DST_TX    = 3'b011,
    DST_TXACK = 3'b100
  } imrid_dst_t;

  typedef enum logic [2:0] {
    KND_DEV  = 3'b000,
    KND_IDW  = 3'b001,
    KND_AHI  = 3'b010,
    KND_ALO  = 3'b011,
    KND_WAIT = 3'b100
  } imrid_kind_t;

  typedef enum logic [1:0] {
    HST_IDLE  = 2'b00,
    HST_START = 2'b01,
    HST_BIT   = 2'b10,
    HST_STOP  = 2'b11
  } imrid_hst_t;

  typedef enum logic [1:0] {
    CMD_RAND  = 2'b00,
    CMD_ID    = 2'b01,
    CMD_RECOV = 2'b10
  } imrid_cmd_t;
endpackage

// ===== rtl/imrid_dev.sv
// imrid_dev: serial memory slave, read side and identification readout
// assumes bus levels from imrid_if, all logic on ref_clk; memory filled via fill port
// How it works
// - write-form address then read word returns byte
// - master ends read with not-acknowledge
// - keep sending while master acknowledges
// - address wraps to zero past last
// - fixed three-byte identification value held
// - reserved word F8 starts identification, acknowledged
// - following device word ignores read/write bit
// - reserved F9 then identification bytes in order
// - acknowledge after third byte restarts at first
// - master never drives data line high
// - master recovers or retries after failures
// - select inputs stable from start to stop
// - respond only to matching type and select
// - fifteen-bit address, high byte first
// - ninth clock carries acknowledge from receiver
`timescale 1ns/1ns
module imrid_dev #(
  // arbitrary neutral value; element 2 goes out first
  parameter logic [2:0][7:0] ID_BYTES = 24'h5a3c01
) (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // two-wire bus
  imrid_if.dev                             bus,
  // select straps
  input  wire logic [2:0]                  selectBits,
  // memory fill port
  input  wire logic                        fillEn,
  input  wire logic [imrid_pkg::ADDR_W-1:0] fillAddr,
  input  wire logic [7:0]                  fillData,
  // status
  output logic                             busy
);
  import imrid_pkg::*;

  typedef struct packed {
    imrid_dst_t        st;
    imrid_kind_t       kind;
    logic [3:0]        bitCnt;
    logic [7:0]        shift;
    logic [ADDR_W-1:0] addr;
    logic              idMode;
    logic              idArmed;
    logic [1:0]        idIdx;
    logic              ackGoTx;
    logic              sclPrev;
    logic              sdaPrev;
    logic [2:0]        sel;
    logic              sdaOut;
    logic              sdaOe;
    logic              busy;
  } imrid_dev_state_t;

  imrid_dev_state_t s_reg;
  imrid_dev_state_t s_next;
  logic [7:0]       mem [MEM_WORDS];
  logic [7:0]       memRd;
  logic [4:0]       pins;
  logic             sclNow;
  logic             sdaNow;
  logic [2:0]       selNow;

  imrid_sync #(.W(5), .RST_VAL('1)) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     ({selectBits, bus.scl, bus.sda}),
    .dout    (pins)
  );

  assign sclNow = pins[1];
  assign sdaNow = pins[0];
  assign selNow = pins[4:2];

  // no write command here: the array is loaded by the fill port only
  always_ff @(posedge ref_clk) begin
    if (fillEn) begin
      mem[fillAddr] <= fillData;
    end
  end

  assign memRd = mem[s_reg.addr];

  always_comb begin
    logic       sclRise;
    logic       sclFall;
    logic       startDet;
    logic       stopDet;
    logic       doLoad;
    logic       match;
    logic       ack;
    logic [7:0] txByte;
    s_next   = s_reg;
    doLoad   = 1'b0;
    ack      = 1'b0;
    sclRise  = sclNow && !s_reg.sclPrev;
    sclFall  = !sclNow && s_reg.sclPrev;
    startDet = sclNow && s_reg.sclPrev && s_reg.sdaPrev && !sdaNow;
    stopDet  = sclNow && s_reg.sclPrev && !s_reg.sdaPrev && sdaNow;
    match    = (s_reg.shift[7:4] == DEV_TYPE) && (s_reg.shift[3:1] == s_reg.sel);
    txByte   = s_reg.idMode ? ID_BYTES[ID_LAST - s_reg.idIdx] : memRd;
    s_next.sclPrev = sclNow;
    s_next.sdaPrev = sdaNow;

    if (stopDet) begin
      // abandon any sequence and free the line
      s_next.st      = DST_IDLE;
      s_next.sdaOe   = 1'b0;
      s_next.idArmed = 1'b0;
      s_next.busy    = 1'b0;
    end else if (startDet) begin
      s_next.st     = DST_RX;
      s_next.kind   = KND_DEV;
      s_next.bitCnt = 4'h0;
      s_next.sdaOe  = 1'b0;
      s_next.busy   = 1'b1;
      // straps taken at every start, repeated start included, relying on them staying put
      s_next.sel    = selNow;
    end else begin
      case (s_reg.st)
        DST_RX: begin
          if (sclRise) begin
            s_next.shift  = {s_reg.shift[6:0], sdaNow};
            s_next.bitCnt = s_reg.bitCnt + 4'h1;
          end else if (sclFall && s_reg.bitCnt == BYTE_BITS) begin
            s_next.bitCnt  = 4'h0;
            s_next.ackGoTx = 1'b0;
            case (s_reg.kind)
              KND_DEV: begin
                if (s_reg.shift == RSV_ID_SET) begin
                  ack            = 1'b1;
                  s_next.kind    = KND_IDW;
                  s_next.idArmed = 1'b0;
                end else if (s_reg.shift == RSV_ID_READ && s_reg.idArmed) begin
                  ack            = 1'b1;
                  s_next.idMode  = 1'b1;
                  s_next.idIdx   = 2'h0;
                  s_next.ackGoTx = 1'b1;
                end else if (match && s_reg.shift[0]) begin
                  ack            = 1'b1;
                  s_next.idMode  = 1'b0;
                  s_next.ackGoTx = 1'b1;
                end else if (match) begin
                  ack         = 1'b1;
                  s_next.kind = KND_AHI;
                end
              end
              KND_IDW: begin
                if (match) begin
                  ack            = 1'b1;
                  s_next.idArmed = 1'b1;
                  s_next.kind    = KND_WAIT;
                end
              end
              KND_AHI: begin
                // top bit of the high byte has no cell behind it
                s_next.addr[ADDR_W-1:8] = s_reg.shift[6:0];
                ack                     = 1'b1;
                s_next.kind             = KND_ALO;
              end
              KND_ALO: begin
                s_next.addr[7:0] = s_reg.shift;
                ack              = 1'b1;
                s_next.kind      = KND_WAIT;
              end
              default: ack = 1'b0;
            endcase
            s_next.sdaOe = ack;
            s_next.st    = ack ? DST_ACK : DST_IDLE;
          end
        end
        DST_ACK: begin
          if (sclFall) begin
            s_next.sdaOe  = 1'b0;
            s_next.bitCnt = 4'h0;
            if (s_reg.ackGoTx) begin
              doLoad = 1'b1;
            end else if (s_reg.kind == KND_WAIT) begin
              s_next.st = DST_IDLE;
            end else begin
              s_next.st = DST_RX;
            end
          end
        end
        DST_TX: begin
          if (sclRise) begin
            s_next.bitCnt = s_reg.bitCnt + 4'h1;
          end else if (sclFall && s_reg.bitCnt == BYTE_BITS) begin
            // release for the master's answer on the ninth clock
            s_next.sdaOe  = 1'b0;
            s_next.st     = DST_TXACK;
          end else if (sclFall) begin
            // open drain: a one is sent by letting go
            s_next.shift = {s_reg.shift[6:0], 1'b0};
            s_next.sdaOe = !s_reg.shift[6];
          end
        end
        DST_TXACK: begin
          if (sclRise && sdaNow) begin
            s_next.st = DST_IDLE;
          end else if (sclRise) begin
            s_next.bitCnt = ACK_SEEN;
          end else if (sclFall && s_reg.bitCnt == ACK_SEEN) begin
            doLoad = 1'b1;
          end
        end
        DST_IDLE: s_next.sdaOe = 1'b0;
        default:  s_next.st = DST_IDLE;
      endcase
    end

    if (doLoad) begin
      s_next.st     = DST_TX;
      s_next.shift  = txByte;
      s_next.sdaOe  = !txByte[7];
      s_next.bitCnt = 4'h0;
      if (s_reg.idMode) begin
        s_next.idIdx = (s_reg.idIdx == ID_LAST) ? 2'h0 : s_reg.idIdx + 2'h1;
      end else begin
        // natural 15-bit overflow gives the wrap to zero
        s_next.addr = s_reg.addr + 15'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{st: DST_IDLE, kind: KND_DEV, bitCnt: 4'h0, shift: 8'h00, addr: 15'h0000,
                 idMode: 1'b0, idArmed: 1'b0, idIdx: 2'h0, ackGoTx: 1'b0, sclPrev: 1'b1,
                 sdaPrev: 1'b1, sel: 3'h0, sdaOut: 1'b0, sdaOe: 1'b0, busy: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.sdaDevOut = s_reg.sdaOut;
  assign bus.sdaDevOe  = s_reg.sdaOe;
  assign busy          = s_reg.busy;
endmodule

// ===== rtl/imrid_host.sv
// imrid_host: bus master issuing random reads, identification reads and recovery
// assumes sole master on the bus; clock derived from ref_clk by a quarter-bit divider
`timescale 1ns/1ns
module imrid_host (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // two-wire bus
  imrid_if.host                            bus,
  // command
  input  wire logic                        cmdValid,
  input  imrid_pkg::imrid_cmd_t            cmdKind,
  input  wire logic [imrid_pkg::ADDR_W-1:0] cmdAddr,
  input  wire logic [2:0]                  cmdSel,
  input  wire logic [7:0]                  cmdCount,
  output logic                             cmdReady,
  // answers
  output logic                             rdValid,
  output logic [7:0]                       rdData,
  output logic                             done,
  output logic                             nackErr
);
  import imrid_pkg::*;

  typedef struct packed {
    imrid_hst_t        st;
    logic [1:0]        q;
    logic [7:0]        qCnt;
    logic [3:0]        bitIdx;
    logic [2:0]        step;
    logic [7:0]        shift;
    logic              rdMode;
    imrid_cmd_t        kind;
    logic [ADDR_W-1:0] addr;
    logic [2:0]        sel;
    logic [7:0]        left;
    logic              err;
    logic              sclOut;
    logic              sdaOe;
    logic              ready;
    logic              rdValid;
    logic [7:0]        rdData;
    logic              done;
    logic              nackErr;
  } imrid_host_state_t;

  imrid_host_state_t s_reg;
  imrid_host_state_t s_next;
  logic              sdaNow;

  imrid_sync #(.W(1), .RST_VAL('1)) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     (bus.sda),
    .dout    (sdaNow)
  );

  function automatic logic [7:0] wrByte(input imrid_host_state_t h, input logic [2:0] st);
    logic rnd;
    rnd = (h.kind == CMD_RAND);
    case (st)
      STEP_W1: wrByte = rnd ? {DEV_TYPE, h.sel, 1'b0} : RSV_ID_SET;
      STEP_W2: wrByte = rnd ? {1'b0, h.addr[ADDR_W-1:8]} : {DEV_TYPE, h.sel, 1'b0};
      STEP_W3: wrByte = h.addr[7:0];
      default: wrByte = rnd ? {DEV_TYPE, h.sel, 1'b1} : RSV_ID_READ;
    endcase
  endfunction

  always_comb begin
    logic       tick;
    logic       endSym;
    logic       launch;
    logic [2:0] lstep;
    s_next         = s_reg;
    launch         = 1'b0;
    lstep          = s_reg.step;
    tick           = (s_reg.qCnt == QTR_LAST);
    endSym         = tick && s_reg.q == Q_LAST;
    s_next.rdValid = 1'b0;
    s_next.done    = 1'b0;
    s_next.nackErr = 1'b0;
    if (s_reg.st != HST_IDLE) begin
      s_next.qCnt = tick ? 8'h00 : s_reg.qCnt + 8'h01;
      s_next.q    = tick ? s_reg.q + 2'h1 : s_reg.q;
    end
    case (s_reg.st)
      HST_IDLE: begin
        if (cmdValid) begin
          s_next.kind   = cmdKind;
          s_next.addr   = cmdAddr;
          s_next.sel    = cmdSel;
          s_next.left   = (cmdCount == 8'h00) ? 8'h01 : cmdCount;
          s_next.err    = 1'b0;
          s_next.step   = STEP_LEAD;
          s_next.q      = 2'h0;
          s_next.qCnt   = 8'h00;
          s_next.bitIdx = 4'h0;
          s_next.rdMode = 1'b1;
          s_next.ready  = 1'b0;
          // recovery opens with nine released clocks to free a stuck slave
          s_next.st     = (cmdKind == CMD_RECOV) ? HST_BIT : HST_START;
        end
      end
      HST_START: begin
        if (endSym) begin
          launch = 1'b1;
          if (s_reg.step == STEP_LEAD) begin
            lstep = STEP_W1;
          end else begin
            lstep = (s_reg.kind == CMD_RECOV) ? STEP_STOP : STEP_W5;
          end
        end
      end
      HST_BIT: begin
        if (endSym && s_reg.bitIdx != BYTE_BITS) begin
          s_next.shift  = {s_reg.shift[6:0], sdaNow};
          s_next.bitIdx = s_reg.bitIdx + 4'h1;
        end else if (endSym && s_reg.rdMode) begin
          launch = 1'b1;
          if (s_reg.step == STEP_LEAD) begin
            lstep = STEP_RESTART;
          end else begin
            s_next.rdValid = 1'b1;
            s_next.rdData  = s_reg.shift;
            s_next.left    = s_reg.left - 8'h01;
            lstep          = (s_reg.left == 8'h01) ? STEP_STOP : STEP_READ;
          end
        end else if (endSym) begin
          launch = 1'b1;
          if (sdaNow) begin
            // refused byte: close the transfer so the caller can retry
            s_next.err = 1'b1;
            lstep      = STEP_STOP;
          end else begin
            case (s_reg.step)
              STEP_W1: lstep = STEP_W2;
              STEP_W2: lstep = (s_reg.kind == CMD_RAND) ? STEP_W3 : STEP_RESTART;
              STEP_W5: lstep = STEP_READ;
              default: lstep = STEP_RESTART;
            endcase
          end
        end
      end
      HST_STOP: begin
        if (endSym) begin
          s_next.st      = HST_IDLE;
          s_next.done    = 1'b1;
          s_next.nackErr = s_reg.err;
          s_next.ready   = 1'b1;
        end
      end
      default: s_next.st = HST_IDLE;
    endcase

    if (launch) begin
      s_next.step   = lstep;
      s_next.bitIdx = 4'h0;
      s_next.shift  = wrByte(s_reg, lstep);
      s_next.rdMode = (lstep == STEP_READ);
      if (lstep == STEP_STOP) begin
        s_next.st = HST_STOP;
      end else if (lstep == STEP_RESTART) begin
        s_next.st = HST_START;
      end else begin
        s_next.st = HST_BIT;
      end
    end

    // clock low in quarters 0-1, high in 2-3; data moves only in quarter 1 or 3
    s_next.sclOut = (s_next.st == HST_IDLE) || s_next.q[1];
    if (s_next.st == HST_IDLE) begin
      s_next.sdaOe = 1'b0;
    end else if (s_next.q != 2'h0) begin
      case (s_next.st)
        HST_START: s_next.sdaOe = (s_next.q == Q_LAST);
        HST_STOP:  s_next.sdaOe = (s_next.q != Q_LAST);
        default: begin
          if (s_next.bitIdx == BYTE_BITS) begin
            // last wanted byte gets a release, others a pull
            s_next.sdaOe = s_next.rdMode && s_next.step != STEP_LEAD && s_next.left != 8'h01;
          end else begin
            s_next.sdaOe = !s_next.rdMode && !s_next.shift[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{st: HST_IDLE, q: 2'h0, qCnt: 8'h00, bitIdx: 4'h0, step: 3'h0, shift: 8'h00,
                 rdMode: 1'b0, kind: CMD_RAND, addr: 15'h0000, sel: 3'h0, left: 8'h00,
                 err: 1'b0, sclOut: 1'b1, sdaOe: 1'b0, ready: 1'b1, rdValid: 1'b0,
                 rdData: 8'h00, done: 1'b0, nackErr: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.sclOut     = s_reg.sclOut;
  assign bus.sclOe      = 1'b1;
  // data is only ever pulled low or released, never pushed high
  assign bus.sdaHostOut = 1'b0;
  assign bus.sdaHostOe  = s_reg.sdaOe;
  assign cmdReady       = s_reg.ready;
  assign rdValid        = s_reg.rdValid;
  assign rdData         = s_reg.rdData;
  assign done           = s_reg.done;
  assign nackErr        = s_reg.nackErr;
endmodule

// ===== rtl/imrid_sync.sv
// imrid_sync: two-flop synchroniser for pin inputs
// assumes inputs are levels; only the second stage is visible
`timescale 1ns/1ns
module imrid_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } imrid_sync_state_t;

  imrid_sync_state_t s_reg;
  imrid_sync_state_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.meta = din;
    s_next.held = s_reg.meta;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{meta: RST_VAL, held: RST_VAL};
    end else begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.held;
endmodule

// ===== tb/i2c_memory_read_and_id_tb_top.sv
// i2c_memory_read_and_id_tb_top: host and memory slave joined, read scenarios
// assumes one 250 MHz clock for both ends and the default bus pacing
`timescale 1ns/1ns
module i2c_memory_read_and_id_tb_top;
  import imrid_pkg::*;
  localparam logic [2:0][7:0] ID_VAL = 24'hc3e1f7; // arbitrary identification value
  localparam logic [2:0]      DEV_SEL = 3'h5; // straps never move mid-transfer
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              fillEn = 1'b0;
  logic [ADDR_W-1:0] fillAddr = '0;
  logic [7:0]        fillData = 8'h00;
  logic              busy;
  logic              cmdValid = 1'b0;
  imrid_cmd_t        cmdKind = CMD_RAND;
  logic [ADDR_W-1:0] cmdAddr = '0;
  logic [2:0]        cmdSel = 3'h0;
  logic [7:0]        cmdCount = 8'h00;
  logic              cmdReady;
  logic              rdValid;
  logic [7:0]        rdData;
  logic              done;
  logic              nackErr;
  logic [7:0]        got[$];
  logic              gotNack;
  int                fail_count = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  imrid_if busLink ();
  imrid_dev #(.ID_BYTES(ID_VAL)) i_imrid_dev (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus(busLink.dev), .selectBits(DEV_SEL), .fillEn(fillEn), .fillAddr(fillAddr),
    .fillData(fillData), .busy(busy));
  imrid_host i_imrid_host (.ref_clk(ref_clk), .rst_n(rst_n), .bus(busLink.host),
    .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdSel(cmdSel),
    .cmdCount(cmdCount), .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData),
    .done(done), .nackErr(nackErr));
  imrid_monitor i_imrid_monitor (.ref_clk(ref_clk), .rst_n(rst_n), .scl(busLink.scl),
    .sda(busLink.sda), .sdaHostOut(busLink.sdaHostOut), .sdaHostOe(busLink.sdaHostOe),
    .sdaDevOut(busLink.sdaDevOut), .sdaDevOe(busLink.sdaDevOe), .selectBits(DEV_SEL));
  always #2 ref_clk = ~ref_clk;
  // whole run is about 97k cycles of bus traffic at this pacing
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 105000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic fill(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    fillEn = 1'b1;
    fillAddr = a;
    fillData = d;
    @(posedge ref_clk);
    #1;
    fillEn = 1'b0;
  endtask
  // one command, then collect every byte until done; the cycle ceiling bounds the wait
  task automatic run_cmd(input imrid_cmd_t k, input logic [ADDR_W-1:0] a,
                         input logic [2:0] s, input logic [7:0] n);
    logic sawBusy;
    sawBusy = 1'b0;
    got.delete();
    @(posedge ref_clk);
    #1;
    while (cmdReady !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    cmdValid = 1'b1;
    cmdKind = k;
    cmdAddr = a;
    cmdSel = s;
    cmdCount = n;
    @(posedge ref_clk);
    #1;
    cmdValid = 1'b0;
    while (done !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      if (rdValid === 1'b1) begin
        got.push_back(rdData);
      end
      if (busy === 1'b1) begin
        sawBusy = 1'b1;
      end
    end
    gotNack = nackErr;
    // slave must be busy inside the frame and idle again once the stop is seen
    check("busy frame", 16'({sawBusy, busy}), 16'h0002);
  endtask
  task automatic t_bad_sel();
    run_cmd(CMD_RAND, 15'h0001, DEV_SEL ^ 3'h2, 8'h01);
    check("sel nack", 16'(gotNack), 16'h0001);
    check("sel count", 16'(got.size()), 16'h0000);
  endtask
  task automatic t_recover();
    run_cmd(CMD_RECOV, 15'h0000, DEV_SEL, 8'h00);
    check("recov nack", 16'(gotNack), 16'h0000);
    check("recov count", 16'(got.size()), 16'h0000);
  endtask
  // last address then wrap, so the roll-over is read back to back
  task automatic t_seq_wrap();
    fill(15'h7fff, 8'h9e);
    fill(15'h0000, 8'h21);
    fill(15'h0001, 8'h47);
    run_cmd(CMD_RAND, 15'h7fff, DEV_SEL, 8'h03);
    check("wrap nack", 16'(gotNack), 16'h0000);
    check("wrap count", 16'(got.size()), 16'h0003);
    check("wrap byte0", 16'(got[0]), 16'h009e);
    check("wrap byte1", 16'(got[1]), 16'h0021);
    check("wrap byte2", 16'(got[2]), 16'h0047);
  endtask
  // four bytes: the fourth proves the restart at the first byte
  task automatic t_id_loop();
    run_cmd(CMD_ID, 15'h0000, DEV_SEL, 8'h04);
    check("id nack", 16'(gotNack), 16'h0000);
    check("id count", 16'(got.size()), 16'h0004);
    for (int i = 0; i < 4; i++) begin
      check("id byte", 16'(got[i]), 16'(ID_VAL[2 - (i % 3)]));
    end
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check("ready after reset", 16'({cmdReady, busy}), 16'h0002);
    t_bad_sel();
    t_recover();
    t_seq_wrap();
    t_id_loop();
    report_and_stop();
  end
endmodule

// ===== tb/imrid_monitor.sv
// imrid_monitor: wire-level checks on the link between host and memory slave
// assumes resolved bus lines from imrid_if and the device select straps
`timescale 1ns/1ns
module imrid_monitor (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // bus
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       sdaHostOut,
  input wire logic       sdaHostOe,
  input wire logic       sdaDevOut,
  input wire logic       sdaDevOe,
  // straps
  input wire logic [2:0] selectBits
);
  typedef struct packed {
    logic       sclQ;
    logic       sdaQ;
    logic       idle;
    logic       first;
    logic [3:0] cnt;
    logic [7:0] sh;
  } imrid_mon_t;
  imrid_mon_t monReg;
  imrid_mon_t monNext;
  logic       sclRise;
  logic       startSeen;
  logic       stopSeen;
  logic       ackRise;
  assign sclRise   = scl & ~monReg.sclQ;
  assign startSeen = scl & monReg.sclQ & monReg.sdaQ & ~sda;
  assign stopSeen  = scl & monReg.sclQ & ~monReg.sdaQ & sda;
  assign ackRise   = sclRise & ~monReg.idle & (monReg.cnt == 4'h8);
  // bit counter restarts on every start; clocks outside a frame still count but raise no acknowledge check
  always_comb begin
    monNext = monReg;
    monNext.sclQ = scl;
    monNext.sdaQ = sda;
    if (startSeen) begin
      monNext.idle = 1'b0;
      monNext.first = 1'b1;
      monNext.cnt = 4'h0;
    end else if (stopSeen) begin
      monNext.idle = 1'b1;
    end else if (ackRise) begin
      monNext.cnt = 4'h0;
      monNext.first = 1'b0;
    end else if (sclRise) begin
      monNext.cnt = monReg.cnt + 4'h1;
      monNext.sh = {monReg.sh[6:0], sda};
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      monReg <= {1'b1, 1'b1, 1'b1, 1'b0, 4'h0, 8'h00};
    end else begin
      monReg <= monNext;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_hostNoHigh; sdaHostOe |-> !sdaHostOut; endproperty
  a_hostNoHigh: assert property (p_hostNoHigh)
    else $error("host drove data high");
  property p_devOnlyLow; sdaDevOe |-> !sdaDevOut; endproperty
  a_devOnlyLow: assert property (p_devOnlyLow)
    else $error("device drove data high");
  property p_devMovesLow; !$stable(sdaDevOe) |-> !scl; endproperty
  a_devMovesLow: assert property (p_devMovesLow)
    else $error("device changed data while clock high");
  property p_devHolds; $rose(sdaDevOe) |=> sdaDevOe [*8]; endproperty
  a_devHolds: assert property (p_devHolds)
    else $error("device pulldown too short");
  property p_sclLowHold; $fell(scl) |-> !scl [*8]; endproperty
  a_sclLowHold: assert property (p_sclLowHold)
    else $error("clock low phase too short");
  property p_idleSilent; monReg.idle |-> !sdaDevOe; endproperty
  a_idleSilent: assert property (p_idleSilent)
    else $error("device drives data after stop");
  property p_selMatch;
    ackRise && monReg.first && monReg.sh[7:4] == 4'ha |-> sda == (monReg.sh[3:1] != selectBits);
  endproperty
  a_selMatch: assert property (p_selMatch)
    else $error("device word acknowledge wrong");
  property p_resvAck; ackRise && monReg.first && monReg.sh == 8'hf8 |-> !sda; endproperty
  a_resvAck: assert property (p_resvAck)
    else $error("reserved word not acknowledged");
  c_start: cover property (startSeen);
  c_stop: cover property (stopSeen);
  c_resvAck: cover property (ackRise && monReg.first && monReg.sh == 8'hf8 && !sda);
endmodule
